// [design/mpps_pkg.sv]
// shared constants and types for the multiphase pulse sequencer
`default_nettype none
package mpps_pkg;
  // ------------------------------------------------------------
  // phases and detection
  // ------------------------------------------------------------
  localparam int NPH          = 4;
  localparam int MIN_PHASES   = 2;
  localparam int PROBE_MV     = 550;
  localparam int THRESH_MV    = 300;
  localparam int DETECT_TICKS = 2;
  // ------------------------------------------------------------
  // clock and master oscillator
  // ------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int MCLK_KHZ     = 1000;
  localparam int MCLK_DIV     = (CLK_MHZ * 1000) / MCLK_KHZ;
  localparam int SYNC_STAGES  = 3;
  // ------------------------------------------------------------
  // positions in the synchronised input vector
  // ------------------------------------------------------------
  localparam int IN_EN        = 0;
  localparam int IN_SD_N      = 1;
  localparam int IN_UV        = 2;
  localparam int IN_DS        = 3;
  localparam int IN_S3        = 4;
  localparam int IN_S4        = 5;
  localparam int IN_TERM      = 6;
  localparam int NIN          = IN_TERM + NPH;
  localparam logic [1:0] PH3_IDX = 2'h2;
  localparam logic [1:0] PH4_IDX = 2'h3;

  typedef enum logic [1:0] {MPPS_IDLE, MPPS_DETECT, MPPS_RUN} mpps_state_t;
endpackage // mpps_pkg
`default_nettype wire

// [design/mpps_osc.sv]
// master oscillator tick generator, restartable
`timescale 1ns/10ps
`default_nettype none
module mpps_osc #(
  parameter int DIV = mpps_pkg::MCLK_DIV
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic restart,
  output var  logic tick
);
  import mpps_pkg::*;
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (restart || cnt_q == LAST) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick <= 1'b0;
    end else if (ce) begin
      tick <= !restart && cnt_q == LAST;
    end
  end
endmodule // mpps_osc
`default_nettype wire

// [design/mpps_sequencer.sv]
// multiphase pulse sequencer: phase-count detection and phase rotation
//
// Function
// - no grounded outputs means four-phase operation
// - fourth grounded gives three, both give two
// - probe third and fourth outputs, mark low ones
// - detection finishes after two master cycles
// - grounded outputs never switch while enabled
// - each phase runs master clock over phase count
// - pulses independent, duty may approach full
// - phase pulses may overlap freely
// - first driver off on shutdown or undervoltage
// - rest driver off also on deep sleep
`timescale 1ns/10ps
`default_nettype none
module mpps_sequencer #(
  parameter int MCLK_DIV = mpps_pkg::MCLK_DIV
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic                    enable_in,
  input  wire logic                    shutdown_in_n,
  input  wire logic                    supply_undervoltage_lock,
  input  wire logic                    deep_sleep_in,
  input  wire logic                    phase3_sense_in,
  input  wire logic                    phase4_sense_in,
  input  wire logic [mpps_pkg::NPH-1:0] term_in,
  output var  logic                    phase1_pulse_out,
  output var  logic                    phase2_pulse_out,
  output var  logic                    phase3_pulse_out,
  output var  logic                    phase3_pulse_oe,
  output var  logic                    phase4_pulse_out,
  output var  logic                    phase4_pulse_oe,
  output var  logic                    probe_drive_out,
  output var  logic                    driver_off_first,
  output var  logic                    driver_off_rest
);
  import mpps_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] clean_q;

  assign raw = {term_in, phase4_sense_in, phase3_sense_in, deep_sleep_in,
                supply_undervoltage_lock, shutdown_in_n, enable_in};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      // change accepted only once stages two and three agree
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_q[gi]    <= 1'b0;
          s2_q[gi]    <= 1'b0;
          s3_q[gi]    <= 1'b0;
          clean_q[gi] <= 1'b0;
        end else if (ce) begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            clean_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic           en_s;
  logic [NPH-1:0] term_s;
  assign en_s   = clean_q[IN_EN];
  assign term_s = clean_q[IN_TERM +: NPH];

  // ------------------------------------------------------------
  // master oscillator
  // ------------------------------------------------------------
  mpps_state_t state_q;
  logic        tick;

  // restarting keeps the two detection cycles aligned to enable
  mpps_osc #(.DIV(MCLK_DIV)) u_osc (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .restart (state_q == MPPS_IDLE),
    .tick    (tick)
  );

  // ------------------------------------------------------------
  // control state
  // ------------------------------------------------------------
  logic [1:0] det_cnt_q;
  logic       det_done;
  assign det_done = tick && det_cnt_q == 2'(DETECT_TICKS - 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= MPPS_IDLE;
    end else if (ce) begin
      unique case (state_q)
        MPPS_IDLE: begin
          if (en_s) state_q <= MPPS_DETECT;
        end
        MPPS_DETECT: begin
          if (!en_s) state_q <= MPPS_IDLE;
          else if (det_done) state_q <= MPPS_RUN;
        end
        MPPS_RUN: begin
          if (!en_s) state_q <= MPPS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      det_cnt_q <= '0;
    end else if (ce) begin
      if (state_q != MPPS_DETECT) det_cnt_q <= '0;
      else if (tick) det_cnt_q <= det_cnt_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // phase-count detection
  // ------------------------------------------------------------
  logic [NPH-1:0] act_q;
  logic [2:0]     nph_q;

  // a low third output drops the fourth as well: it cannot follow a gap
  always_ff @(posedge clk) begin
    if (srst) begin
      act_q <= '0;
      nph_q <= '0;
    end else if (ce) begin
      if (!en_s) begin
        act_q <= '0;
        nph_q <= '0;
      end else if (state_q == MPPS_DETECT && det_done) begin
        act_q <= {clean_q[IN_S3] & clean_q[IN_S4], clean_q[IN_S3], 2'h3};
        nph_q <= 3'(MIN_PHASES) + {2'h0, clean_q[IN_S3]}
                 + {2'h0, clean_q[IN_S3] & clean_q[IN_S4]};
      end
    end
  end

  // ------------------------------------------------------------
  // phase rotation and pulses
  // ------------------------------------------------------------
  logic [1:0] ptr_q;
  logic [1:0] ptr_next;
  assign ptr_next = (ptr_q == 2'(nph_q - 3'h1)) ? 2'h0 : ptr_q + 2'h1;

  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_q <= '0;
    end else if (ce) begin
      if (state_q != MPPS_RUN) ptr_q <= '0;
      else if (tick) ptr_q <= ptr_next;
    end
  end

  logic [NPH-1:0] pulse_q;
  generate
    for (gi = 0; gi < NPH; gi++) begin : g_phase
      // no mutual exclusion: each phase only looks at its own comparator
      always_ff @(posedge clk) begin
        if (srst) begin
          pulse_q[gi] <= 1'b0;
        end else if (ce) begin
          if (state_q != MPPS_RUN || !en_s || !act_q[gi]) begin
            pulse_q[gi] <= 1'b0;
          end else if (tick && ptr_q == 2'(gi)) begin
            pulse_q[gi] <= 1'b1;
          end else if (term_s[gi]) begin
            pulse_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign phase1_pulse_out = pulse_q[0];
  assign phase2_pulse_out = pulse_q[1];
  assign phase3_pulse_out = pulse_q[PH3_IDX];
  assign phase4_pulse_out = pulse_q[PH4_IDX];
  // pin released to the probe during detection, driven in idle, driven in run only if not grounded
  assign phase3_pulse_oe  = state_q == MPPS_IDLE || (state_q == MPPS_RUN && act_q[PH3_IDX]);
  assign phase4_pulse_oe  = state_q == MPPS_IDLE || (state_q == MPPS_RUN && act_q[PH4_IDX]);
  assign probe_drive_out  = state_q == MPPS_DETECT;

  // ------------------------------------------------------------
  // driver shutdown outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      driver_off_first <= 1'b0;
      driver_off_rest  <= 1'b0;
    end else if (ce) begin
      driver_off_first <= clean_q[IN_SD_N] & ~clean_q[IN_UV];
      driver_off_rest  <= clean_q[IN_SD_N] & ~clean_q[IN_UV] & ~clean_q[IN_DS];
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_enter_run;
    ce && state_q == MPPS_DETECT && en_s && det_done;
  endsequence

  a_detect_bound: assert property (@(posedge clk) disable iff (srst)
    s_enter_run |=> state_q == MPPS_RUN && $past(det_cnt_q) == 2'h1)
    else $error("detection did not end after two master cycles");

  a_count_map: assert property (@(posedge clk) disable iff (srst)
    s_enter_run |=> nph_q == ($past(clean_q[IN_S4]) && $past(clean_q[IN_S3]) ? 3'h4 :
                              $past(clean_q[IN_S3]) ? 3'h3 : 3'h2))
    else $error("phase count does not match probe result");

  a_probe_pins: assert property (@(posedge clk) disable iff (srst)
    state_q == MPPS_DETECT |-> probe_drive_out && !phase3_pulse_oe && !phase4_pulse_oe)
    else $error("third or fourth output driven while probing");

  a_grounded_quiet: assert property (@(posedge clk) disable iff (srst)
    state_q == MPPS_RUN && !act_q[PH4_IDX] |-> !phase4_pulse_out && !phase4_pulse_oe)
    else $error("grounded fourth phase switched");

  a_grounded_third: assert property (@(posedge clk) disable iff (srst)
    state_q == MPPS_RUN && !act_q[PH3_IDX] |-> !phase3_pulse_out && !phase3_pulse_oe)
    else $error("grounded third phase switched");

  a_rotation: assert property (@(posedge clk) disable iff (srst)
    ce && state_q == MPPS_RUN && en_s && tick |=>
      ptr_q == 2'(({1'b0, $past(ptr_q)} + 3'h1) % $past(nph_q)))
    else $error("phase pointer skipped or stalled");

  a_pulse_start: assert property (@(posedge clk) disable iff (srst)
    ce && state_q == MPPS_RUN && en_s && tick && act_q[ptr_q] |=> pulse_q[$past(ptr_q)])
    else $error("active phase did not start on its tick");

  a_pulse_hold: assert property (@(posedge clk) disable iff (srst)
    ce && state_q == MPPS_RUN && en_s && pulse_q[0] && !term_s[0] |=> pulse_q[0])
    else $error("pulse ended without its comparator");

  a_disable_clear: assert property (@(posedge clk) disable iff (srst)
    ce && !en_s |=> pulse_q == '0 && act_q == '0 && nph_q == '0)
    else $error("disable left pulses or phase count");

  a_off_first: assert property (@(posedge clk) disable iff (srst)
    ce && (!clean_q[IN_SD_N] || clean_q[IN_UV]) |=> !driver_off_first)
    else $error("first driver not shut off");

  a_off_rest: assert property (@(posedge clk) disable iff (srst)
    ce && (clean_q[IN_DS] || clean_q[IN_UV] || !clean_q[IN_SD_N]) |=> !driver_off_rest)
    else $error("rest drivers not shut off");
endmodule // mpps_sequencer
`default_nettype wire

// [tb/mpps_drv_model.sv]
// board-side model: phase pin ties, ramp comparators and gate drivers
`timescale 1ns/10ps
`default_nettype none
module mpps_drv_model (
  input  wire logic       clk,
  input  wire logic [3:0] pulse,
  input  wire logic       oe3,
  input  wire logic       oe4,
  input  wire logic       probe,
  input  wire logic       gnd3,
  input  wire logic       gnd4,
  input  wire logic       off1,
  input  wire logic       off2,
  input  wire logic [7:0] dly,
  output var  logic       sense3,
  output var  logic       sense4,
  output var  logic [3:0] term,
  output var  logic [3:0] gate_on
);
  int unsigned cnt [4];
  // a tied pin always reads ground, whoever tries to drive it
  assign sense3 = ~gnd3 & (oe3 ? pulse[2] : probe);
  assign sense4 = ~gnd4 & (oe4 ? pulse[3] : probe);
  assign gate_on = pulse & {off2, off2, off2, off1};
  // comparator trips dly cycles into the pulse and stays until the pulse drops
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      cnt[k] = (pulse[k] === 1'b1) ? cnt[k] + 1 : 0;
      term[k] <= (pulse[k] === 1'b1) && (cnt[k] >= dly);
    end
  end
endmodule // mpps_drv_model
`default_nettype wire

// [tb/multiphase_pwm_phase_sequencer_tb_top.sv]
// self-checking testbench for the multiphase pulse sequencer
`timescale 1ns/10ps
`default_nettype none
module multiphase_pwm_phase_sequencer_tb_top;
  import mpps_pkg::*;
  // short master period keeps the run brief
  localparam int DIV = 8;
  // comparator seen through the input synchroniser, then the pulse flop
  localparam int TERM_LAT = SYNC_STAGES + 2;
  logic           clk;
  logic           srst;
  logic           ce;
  logic           enable_in;
  logic           sd_n;
  logic           uv;
  logic           ds;
  logic           gnd3;
  logic           gnd4;
  logic           s3;
  logic           s4;
  logic           oe3;
  logic           oe4;
  logic           probe;
  logic           off1;
  logic           off2;
  logic [7:0]     dly;
  logic [NPH-1:0] pulse;
  logic [NPH-1:0] pulse_p;
  logic [NPH-1:0] term;
  logic [1:0]     exp_q[$];
  logic [1:0]     cfg[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int             nphs[4] = '{4, 3, 2, 2};
  int             failures = 0;
  int             checked = 0;
  int             last_start = -1;
  int             overlap = 0;
  int             cyc = 0;
  int             w;
  int             np;
  int             hi[NPH] = '{default: 0};

  mpps_sequencer #(.MCLK_DIV(DIV)) mpps_sequencer_i (
    .clk(clk), .srst(srst), .ce(ce), .enable_in(enable_in), .shutdown_in_n(sd_n),
    .supply_undervoltage_lock(uv), .deep_sleep_in(ds), .phase3_sense_in(s3),
    .phase4_sense_in(s4), .term_in(term), .phase1_pulse_out(pulse[0]),
    .phase2_pulse_out(pulse[1]), .phase3_pulse_out(pulse[2]), .phase3_pulse_oe(oe3),
    .phase4_pulse_out(pulse[3]), .phase4_pulse_oe(oe4), .probe_drive_out(probe),
    .driver_off_first(off1), .driver_off_rest(off2));

  mpps_drv_model mpps_drv_model_i (
    .clk(clk), .pulse(pulse), .oe3(oe3), .oe4(oe4), .probe(probe), .gnd3(gnd3),
    .gnd4(gnd4), .off1(off1), .off2(off2), .dly(dly), .sense3(s3), .sense4(s4),
    .term(term), .gate_on());

  task automatic fail_if(input logic bad, input string msg);
    checked++;
    if (bad !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_if(1'b1, "run timed out");
    close_out();
  end

  // ------------------------------------------------------------
  // watcher: each phase start takes the oldest expected phase
  // ------------------------------------------------------------
  initial pulse_p = '0;
  always @(posedge clk) begin
    cyc++;
    if ($countones(pulse) > 1) overlap++;
    for (int k = 0; k < NPH; k++) begin
      if (pulse[k] === 1'b1 && pulse_p[k] !== 1'b1) begin
        fail_if(exp_q.size() == 0 || exp_q.pop_front() !== 2'(k), "wrong phase start");
        if (last_start >= 0) fail_if(cyc - last_start != DIV, "start spacing");
        last_start = cyc;
      end
      if (pulse[k] === 1'b1) hi[k]++;
      // a pulse cut short by disable has no comparator end to check
      if (pulse[k] !== 1'b1 && pulse_p[k] === 1'b1) begin
        if (enable_in === 1'b1) begin
          fail_if(hi[k] != dly + TERM_LAT, "pulse ended off its comparator");
        end
        hi[k] = 0;
      end
    end
    pulse_p = pulse;
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    void'($urandom(55973));
    srst = 1'b1;
    ce = 1'b1;
    enable_in = 1'b0;
    {sd_n, uv, ds, gnd3, gnd4} = 5'h10;
    dly = 8'h04;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    fail_if(pulse !== 4'h0 || oe3 !== 1'b1 || oe4 !== 1'b1 || probe !== 1'b0 ||
            off1 !== 1'b0 || off2 !== 1'b0, "outputs after reset");
    for (int v = 0; v < 8; v++) begin
      {sd_n, uv, ds} = 3'(v);
      repeat (7) @(posedge clk);
      #1;
      fail_if(off1 !== (sd_n & ~uv), "first driver off");
      fail_if(off2 !== (sd_n & ~uv & ~ds), "rest driver off");
    end
    // clock enable low must freeze the driver-off flops and their synchronisers
    ce = 1'b0;
    {sd_n, uv, ds} = 3'h4;
    repeat (7) @(posedge clk);
    #1;
    fail_if(off1 !== 1'b0 || off2 !== 1'b0, "outputs moved with clock enable low");
    ce = 1'b1;
    for (int c = 0; c < 4; c++) begin
      {gnd3, gnd4} = cfg[c];
      np = nphs[c];
      // long comparator delay on four phases forces overlap and a duty above half
      dly = 8'((np == 4) ? 12 + $urandom % 10 : 1 + $urandom % 6);
      last_start = -1;
      overlap = 0;
      for (int n = 0; n < 3 * np; n++) exp_q.push_back(2'(n % np));
      enable_in = 1'b1;
      for (w = 0; probe !== 1'b1 && w < 40; w++) begin
        @(posedge clk);
        #1;
      end
      fail_if(w >= 40, "probe never driven");
      for (w = 0; probe === 1'b1 && w < 40; w++) begin
        @(posedge clk);
        #1;
      end
      fail_if(w < 2 * DIV || w > 2 * DIV + 2, "detect length");
      fail_if(exp_q.size() != 3 * np, "start during detect");
      #1;
      fail_if(oe3 !== ~gnd3 || oe4 !== (~gnd3 & ~gnd4), "pin drive after detect");
      for (w = 0; exp_q.size() != 0 && w < 200; w++) begin
        @(posedge clk);
        #1;
      end
      fail_if(w >= 200, "phase starts missing");
      if (np == 4) fail_if(overlap == 0, "no overlap seen");
      enable_in = 1'b0;
      repeat (7) @(posedge clk);
      #1;
      fail_if(pulse !== 4'h0 || probe !== 1'b0, "outputs after disable");
      fail_if(oe3 !== 1'b1 || oe4 !== 1'b1, "idle pins not held low");
    end
    close_out();
  end
endmodule // multiphase_pwm_phase_sequencer_tb_top
`default_nettype wire
